// ===== hw/tzwp_pkg.sv
package tzwp_pkg;

  // Register port geometry.
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_TIMER_COUNT  = 9'h001;
  localparam logic [ADDR_W-1:0] ADDR_INT_CONTROL  = 9'h00B;
  localparam logic [ADDR_W-1:0] ADDR_CORE_OPTIONS = 9'h081;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = 9'h090;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK     = 9'h091;

  // Field positions of core_options.
  localparam int OPT_SOURCE_BIT = 5;
  localparam int OPT_EDGE_BIT   = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_SELECT_LSB = 0;
  localparam int OPT_SELECT_W   = 3;

  // Field positions of interrupt_control.
  localparam int INT_ENABLE_BIT = 5;
  localparam int INT_FLAG_BIT   = 2;

  // Field position of the overflow bit in the status and mask registers.
  localparam int IRQ_OVERFLOW_BIT = 0;

  // Values after reset, and the top count of the timer.
  localparam logic [DATA_W-1:0] CORE_OPTIONS_RESET = 8'hFF;
  localparam logic              INT_BIT_RESET      = 1'b0;
  localparam logic [DATA_W-1:0] PRESCALE_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE          = 8'h00;
  localparam logic [DATA_W-1:0] TIMER_TOP          = 8'hFF;

  // Instruction cycles during which a write to the counter stops counting.
  localparam int INHIBIT_CYCLES = 2;
  localparam logic [1:0] INHIBIT_LOAD = 2'(INHIBIT_CYCLES);

endpackage

// ===== hw/tzwp_timer_zero.sv
`timescale 1ns/10ps
`default_nettype none

module tzwp_timer_zero (
  // Clock and reset.
  input  wire  logic                          clk,
  input  wire  logic                          rst,
  // Register port.
  input  wire  logic [tzwp_pkg::ADDR_W-1:0]   address,
  input  wire  logic [tzwp_pkg::DATA_W-1:0]   writeData,
  input  wire  logic                          writeStrobe,
  input  wire  logic                          readStrobe,
  output var   logic [tzwp_pkg::DATA_W-1:0]   readData,
  // Core status and watchdog link.
  input  wire  logic                          sleepMode,
  input  wire  logic                          watchdogTick,
  input  wire  logic                          watchdogClear,
  output var   logic                          watchdogTimeout,
  // External count pin.
  input  wire  logic                          externalCountPin,
  // Interrupts.
  output var   logic                          timerIntReq,
  output var   logic                          irq
);
  import tzwp_pkg::*;

  logic [DATA_W-1:0]       timerCount;
  logic [DATA_W-1:0]       coreOptions;
  logic [DATA_W-1:0]       prescaleCount;
  logic [1:0]              inhibitCount;
  logic                    overflowFlag;
  logic                    overflowIntEnable;
  logic                    irqStatus;
  logic                    irqMask;
  logic                    pinSync1;
  logic                    pinSync2;
  logic                    pinPrev;

  wire                     wrCount;
  wire                     wrIntCtl;
  wire                     wrOptions;
  wire                     wrStatus;
  wire                     wrMask;
  wire                     countSourceSelect;
  wire                     countEdgeSelect;
  wire                     prescalerAssign;
  wire [OPT_SELECT_W-1:0]  prescaleSelect;
  wire                     riseEdge;
  wire                     fallEdge;
  wire                     sourceEvent;
  wire                     timerRun;
  wire                     prescaleIn;
  wire [DATA_W-1:0]        maskTimer;
  wire [DATA_W-1:0]        maskWatchdog;
  wire [DATA_W-1:0]        prescaleMask;
  wire                     prescaleOut;
  wire                     prescaleClear;
  wire                     countStep;
  wire                     countInc;
  wire                     overflowEvent;
  wire [DATA_W-1:0]        intCtlView;
  wire [DATA_W-1:0]        readMux;
  wire [DATA_W-1:0]        next_prescaleCount;
  wire [DATA_W-1:0]        next_timerCount;
  wire [1:0]               next_inhibitCount;
  wire                     next_overflowFlag;
  wire                     next_irqStatus;

  assign wrCount   = writeStrobe && (address == ADDR_TIMER_COUNT);
  assign wrIntCtl  = writeStrobe && (address == ADDR_INT_CONTROL);
  assign wrOptions = writeStrobe && (address == ADDR_CORE_OPTIONS);
  assign wrStatus  = writeStrobe && (address == ADDR_IRQ_STATUS);
  assign wrMask    = writeStrobe && (address == ADDR_IRQ_MASK);

  assign countSourceSelect = coreOptions[OPT_SOURCE_BIT];
  assign countEdgeSelect   = coreOptions[OPT_EDGE_BIT];
  assign prescalerAssign   = coreOptions[OPT_ASSIGN_BIT];
  assign prescaleSelect    = coreOptions[OPT_SELECT_LSB +: OPT_SELECT_W];

  // Pin edge detection
  // Edges are taken between the second stage and its delayed copy only.
  assign riseEdge = pinSync2 && !pinPrev;
  assign fallEdge = !pinSync2 && pinPrev;

  assign sourceEvent = countSourceSelect ? (countEdgeSelect ? fallEdge : riseEdge) : 1'b1;

  assign timerRun = !sleepMode && !rst;

  assign prescaleIn = prescalerAssign ? watchdogTick : (sourceEvent && timerRun);

  // Ratio masks
  // The mask keeps the low select-dependent bits; a full mask marks the last event of a period.
  assign maskTimer    = TIMER_TOP >> (3'd7 - prescaleSelect);
  assign maskWatchdog = TIMER_TOP >> (4'd8 - {1'b0, prescaleSelect});
  assign prescaleMask = prescalerAssign ? maskWatchdog : maskTimer;
  assign prescaleOut  = prescaleIn && ((prescaleCount & prescaleMask) == prescaleMask);

  assign prescaleClear = (wrCount && !prescalerAssign) || (watchdogClear && prescalerAssign);
  assign next_prescaleCount = prescaleClear ? PRESCALE_RESET :
                              prescaleIn ? prescaleCount + 8'h01 : prescaleCount;

  // Write inhibit window
  // A prescaler output that lands inside the window is lost, not deferred.
  // Software that writes an adjusted value must allow for that lost step.
  assign countStep = prescalerAssign ? (sourceEvent && timerRun) : prescaleOut;
  assign countInc  = countStep && (inhibitCount == 2'd0) && !wrCount;
  assign next_inhibitCount = wrCount ? INHIBIT_LOAD :
                             (inhibitCount != 2'd0) ? inhibitCount - 2'd1 : inhibitCount;

  assign next_timerCount = wrCount ? writeData : countInc ? timerCount + 8'h01 : timerCount;

  // Rollover detection
  // A set from rollover beats a software clear in the same cycle.
  assign overflowEvent     = countInc && (timerCount == TIMER_TOP);
  assign next_overflowFlag = overflowEvent || (wrIntCtl ? writeData[INT_FLAG_BIT] : overflowFlag);
  assign next_irqStatus    = overflowEvent ||
                             (irqStatus && !(wrStatus && writeData[IRQ_OVERFLOW_BIT]));

  // Register read view
  // The prescaler has no address, so it can never be read or written.
  assign intCtlView = (ZERO_BYTE | ({7'h00, overflowIntEnable} << INT_ENABLE_BIT))
                    | ({7'h00, overflowFlag} << INT_FLAG_BIT);
  assign readMux = (address == ADDR_TIMER_COUNT)  ? timerCount :
                   (address == ADDR_INT_CONTROL)  ? intCtlView :
                   (address == ADDR_CORE_OPTIONS) ? coreOptions :
                   (address == ADDR_IRQ_STATUS)   ? {7'h00, irqStatus} :
                   (address == ADDR_IRQ_MASK)     ? {7'h00, irqMask} : ZERO_BYTE;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
      pinPrev  <= 1'b0;
    end else begin
      pinSync1 <= externalCountPin;
      pinSync2 <= pinSync1;
      pinPrev  <= pinSync2;
    end
  end

  // Counter kept through reset
  // Left without reset on purpose; its value after power-up is undefined.
  always_ff @(posedge clk) begin
    timerCount <= next_timerCount;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      coreOptions <= CORE_OPTIONS_RESET;
    end else if (wrOptions) begin
      coreOptions <= writeData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prescaleCount <= PRESCALE_RESET;
      inhibitCount  <= 2'd0;
    end else begin
      prescaleCount <= next_prescaleCount;
      inhibitCount  <= next_inhibitCount;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overflowFlag      <= INT_BIT_RESET;
      overflowIntEnable <= INT_BIT_RESET;
    end else begin
      overflowFlag <= next_overflowFlag;
      if (wrIntCtl) begin
        overflowIntEnable <= writeData[INT_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= INT_BIT_RESET;
      irqMask   <= INT_BIT_RESET;
    end else begin
      irqStatus <= next_irqStatus;
      if (wrMask) begin
        irqMask <= writeData[IRQ_OVERFLOW_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timerIntReq     <= 1'b0;
      irq             <= 1'b0;
      watchdogTimeout <= 1'b0;
      readData        <= ZERO_BYTE;
    end else begin
      timerIntReq     <= overflowFlag && overflowIntEnable;
      irq             <= irqStatus && irqMask;
      watchdogTimeout <= prescalerAssign ? prescaleOut : watchdogTick;
      readData        <= readStrobe ? readMux : ZERO_BYTE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_quietInternal;
    !countSourceSelect && prescalerAssign && !sleepMode && !writeStrobe && (inhibitCount == 2'd0);
  endsequence

  sequence s_divideByTwo;
    !countSourceSelect && !prescalerAssign && (prescaleSelect == 3'd0) && !sleepMode && !writeStrobe;
  endsequence

  sequence s_countWrite;
    wrCount ##1 !wrCount [*2];
  endsequence

  chk_internal_rate: assert property (
    s_quietInternal |=> (timerCount == $past(timerCount) + 8'h01))
    else $error("Internal count did not advance each cycle.");

  chk_write_inhibit: assert property (
    s_countWrite |-> $stable(timerCount) and (timerCount == $past(writeData, 2)))
    else $error("Counter advanced inside the write inhibit window.");

  chk_edge_count: assert property (
    countSourceSelect && prescalerAssign && !wrCount && (inhibitCount == 2'd0) && !sleepMode
    |-> (countInc == (countEdgeSelect ? fallEdge : riseEdge)))
    else $error("External count did not follow the selected edge.");

  chk_sync_delay: assert property (
    countInc && countSourceSelect |-> ($past(externalCountPin, 2) != $past(externalCountPin, 3)))
    else $error("External edge counted without synchroniser delay.");

  // Without the prescaler the watchdog sees every tick, one cycle later.
  chk_prescale_owner: assert property (
    !$past(prescalerAssign) && !$past(rst) |-> (watchdogTimeout == $past(watchdogTick)))
    else $error("Watchdog was divided while prescaler belonged to timer.");

  chk_timer_divide: assert property (
    (countInc and s_divideByTwo) ##1 s_divideByTwo |-> !countInc)
    else $error("Timer ratio 1:2 counted on consecutive cycles.");

  chk_watchdog_direct: assert property (
    prescalerAssign && (prescaleSelect == 3'd0) && watchdogTick && !watchdogClear |=> watchdogTimeout)
    else $error("Watchdog ratio 1:1 did not pass the tick.");

  chk_write_clear: assert property (
    wrCount && !prescalerAssign |=> (prescaleCount == PRESCALE_RESET) && !prescalerAssign)
    else $error("Counter write did not clear the prescaler.");

  chk_wdt_clear: assert property (
    watchdogClear && prescalerAssign |=> (prescaleCount == PRESCALE_RESET))
    else $error("Watchdog clear did not clear the prescaler.");

  chk_overflow_set: assert property (
    countInc && (timerCount == TIMER_TOP) |=> overflowFlag && (timerCount == ZERO_BYTE) && irqStatus)
    else $error("Rollover did not set the overflow flag.");

  chk_request_mask: assert property (
    timerIntReq |-> $past(overflowFlag) && $past(overflowIntEnable))
    else $error("Timer request raised while masked.");

  chk_sleep_stop: assert property (
    sleepMode |=> (timerCount == $past(timerCount)) || $past(wrCount))
    else $error("Counter advanced during sleep.");

  chk_reset_options: assert property (
    $past(rst) |-> (coreOptions == CORE_OPTIONS_RESET) && !overflowFlag && !overflowIntEnable)
    else $error("Reset values of options or interrupt control wrong.");

  chk_read_timing: assert property (
    readStrobe && (address == ADDR_CORE_OPTIONS) && !$past(rst) |=> (readData == $past(coreOptions)))
    else $error("Read data did not appear one cycle after the strobe.");

  sequence s_flagHeld;
    overflowFlag && !wrIntCtl;
  endsequence

  sequence s_setAgainstClear;
    overflowEvent && wrIntCtl && !writeData[INT_FLAG_BIT];
  endsequence

  // The third cycle after a write is the first that may count.
  chk_inhibit_end: assert property (
    s_countWrite |=> (timerCount == $past(writeData, 3)))
    else $error("Counter advanced in the second inhibit cycle.");

  chk_prescale_hidden: assert property (
    !prescaleClear && !prescaleIn |=> $stable(prescaleCount))
    else $error("Prescaler changed without an event or a clear.");

  chk_timer_slowest: assert property (
    !prescalerAssign && (prescaleSelect == 3'd7) && (prescaleCount != TIMER_TOP) |-> !countInc)
    else $error("Timer ratio 1:256 counted early.");

  chk_watchdog_ratio: assert property (
    prescalerAssign && (prescaleSelect == 3'd1) && watchdogTick && !prescaleCount[0] |=> !watchdogTimeout)
    else $error("Watchdog ratio 1:2 passed an odd tick.");

  chk_flag_sticky: assert property (
    s_flagHeld |=> overflowFlag)
    else $error("Overflow flag dropped without a software clear.");

  chk_set_wins: assert property (
    s_setAgainstClear |=> overflowFlag)
    else $error("Software clear beat a rollover in the same cycle.");

  chk_request_raise: assert property (
    overflowFlag && overflowIntEnable |=> timerIntReq)
    else $error("Enabled overflow did not raise the timer request.");

  chk_request_masked: assert property (
    !overflowIntEnable |=> !timerIntReq)
    else $error("Timer request raised with the enable clear.");

  chk_irq_level: assert property (
    irqStatus && irqMask |=> irq)
    else $error("Unmasked status did not raise the interrupt.");

  chk_irq_masked: assert property (
    !irqMask |=> !irq)
    else $error("Interrupt raised while masked.");

  // The timer-owned prescaler must freeze too, or a wake-up would see a part step.
  chk_sleep_prescale: assert property (
    sleepMode && !prescalerAssign && !wrCount |=> $stable(prescaleCount))
    else $error("Timer-owned prescaler ran during sleep.");

  chk_reset_outputs: assert property (
    $past(rst) |-> !timerIntReq && !irq && !watchdogTimeout && (readData == ZERO_BYTE))
    else $error("Outputs not quiet after reset.");

  chk_idle_read: assert property (
    !readStrobe |=> (readData == ZERO_BYTE))
    else $error("Read data stood outside the read cycle.");

endmodule

`default_nettype wire

// ===== verification/timer_zero_with_prescaler_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errTotal++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module timer_zero_with_prescaler_bench;
  import tzwp_pkg::*;
  typedef struct packed {logic [7:0] opt; logic [15:0] waitCyc; logic [7:0] cnt;} tzwp_row_s;
  // Timer-owned ratios 2 to 256; at 1:2 the inhibit window swallows the first step.
  localparam tzwp_row_s ROWS [8] = '{'{8'h00, 16'h0007, 8'h03},
    '{8'h01, 16'h000E, 8'h03}, '{8'h02, 16'h001C, 8'h03},
    '{8'h03, 16'h0038, 8'h03}, '{8'h04, 16'h0070, 8'h03}, '{8'h05, 16'h00E0, 8'h03},
    '{8'h06, 16'h01C0, 8'h03}, '{8'h07, 16'h0380, 8'h03}};
  logic              clk, rst, writeStrobe, readStrobe, sleepMode;
  logic              watchdogTick, watchdogClear, externalCountPin;
  logic              watchdogTimeout, timerIntReq, irq;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writeData, readData, rd;
  int                errTotal, compares, timeouts;
  logic [7:0]        seq [4] = '{8'hFD, 8'hFD, 8'hFD, 8'hFE};

  tzwp_timer_zero i_dut (.clk(clk), .rst(rst), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .sleepMode(sleepMode),
    .watchdogTick(watchdogTick), .watchdogClear(watchdogClear), .watchdogTimeout(watchdogTimeout),
    .externalCountPin(externalCountPin), .timerIntReq(timerIntReq), .irq(irq));
  tzwp_pin_source i_pin (.clk(clk), .pin(externalCountPin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (watchdogTimeout === 1'b1) timeouts++;

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    address <= a; writeData <= d; writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask
  task automatic rdReg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    address <= a; readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask
  task automatic pulse(input int n, input bit clr);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (clr) watchdogClear <= 1'b1; else watchdogTick <= 1'b1;
      @(posedge clk);
      watchdogClear <= 1'b0; watchdogTick <= 1'b0;
    end
  endtask
  task automatic completeRun();
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    errTotal++;
    completeRun();
  end

  initial begin
    rst = 1'b1; writeStrobe = 1'b0; readStrobe = 1'b0; sleepMode = 1'b0;
    watchdogTick = 1'b0; watchdogClear = 1'b0; address = '0; writeData = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdReg(ADDR_CORE_OPTIONS, rd); `CHK("options", 8'hFF, rd)
    rdReg(ADDR_INT_CONTROL, rd); `CHK("intctl", 8'h00, rd)
    rdReg(9'h1FF, rd); `CHK("unmapped", 8'h00, rd)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CORE_OPTIONS, ROWS[i].opt);
      wr(ADDR_TIMER_COUNT, 8'h00);
      repeat (ROWS[i].waitCyc) @(posedge clk);
      rdReg(ADDR_TIMER_COUNT, rd); `CHK("prescaled", ROWS[i].cnt, rd)
    end
    $display("test prescaler table done");
    wr(ADDR_TIMER_COUNT, 8'h00); pulse(1, 1'b1);
    wr(ADDR_CORE_OPTIONS, 8'h08);
    @(posedge clk);
    address <= ADDR_TIMER_COUNT; writeData <= 8'hFD; writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0; readStrobe <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (i == 3) readStrobe <= 1'b0;
      #1 `CHK("inhibit", seq[i], readData)
    end
    $display("test inhibit done");
    wr(ADDR_CORE_OPTIONS, 8'h28); wr(ADDR_TIMER_COUNT, 8'h00);
    i_pin.toggle(5); repeat (6) @(posedge clk);
    rdReg(ADDR_TIMER_COUNT, rd); `CHK("rising", 8'h03, rd)
    wr(ADDR_CORE_OPTIONS, 8'h38); wr(ADDR_TIMER_COUNT, 8'h00);
    i_pin.toggle(3); repeat (6) @(posedge clk);
    rdReg(ADDR_TIMER_COUNT, rd); `CHK("falling", 8'h02, rd)
    $display("test pin done");
    wr(ADDR_CORE_OPTIONS, 8'h08); wr(ADDR_IRQ_MASK, 8'h01); wr(ADDR_INT_CONTROL, 8'h20);
    wr(ADDR_TIMER_COUNT, 8'hFE);
    repeat (8) @(posedge clk);
    #1 `CHK("intreq", 1'b1, timerIntReq)
    `CHK("irq", 1'b1, irq)
    rdReg(ADDR_INT_CONTROL, rd); `CHK("flag", 8'h24, rd)
    wr(ADDR_INT_CONTROL, 8'h04); repeat (2) @(posedge clk);
    #1 `CHK("masked", 1'b0, timerIntReq)
    rdReg(ADDR_INT_CONTROL, rd); `CHK("sticky", 8'h04, rd)
    wr(ADDR_IRQ_MASK, 8'h00); repeat (2) @(posedge clk);
    #1 `CHK("irqmask", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 8'h01); repeat (2) @(posedge clk);
    #1 `CHK("irqunmask", 1'b1, irq)
    wr(ADDR_IRQ_STATUS, 8'h01); repeat (2) @(posedge clk);
    #1 `CHK("irqclear", 1'b0, irq)
    wr(ADDR_INT_CONTROL, 8'h00);
    rdReg(ADDR_INT_CONTROL, rd); `CHK("flagclear", 8'h00, rd)
    $display("test interrupt done");
    @(posedge clk);
    sleepMode <= 1'b1;
    wr(ADDR_TIMER_COUNT, 8'h40); repeat (20) @(posedge clk);
    rdReg(ADDR_TIMER_COUNT, rd); `CHK("sleep", 8'h40, rd)
    @(posedge clk);
    sleepMode <= 1'b0;
    $display("test sleep done");
    wr(ADDR_CORE_OPTIONS, 8'h0A); pulse(1, 1'b1); repeat (2) @(posedge clk);
    timeouts = 0;
    pulse(8, 1'b0); repeat (3) @(posedge clk);
    `CHK("post4", 2, timeouts)
    pulse(2, 1'b0); pulse(1, 1'b1); pulse(3, 1'b0); repeat (3) @(posedge clk);
    `CHK("wdclear", 2, timeouts)
    pulse(1, 1'b0); repeat (3) @(posedge clk);
    `CHK("wdafter", 3, timeouts)
    wr(ADDR_CORE_OPTIONS, 8'h08); pulse(3, 1'b0); repeat (3) @(posedge clk);
    `CHK("post1", 6, timeouts)
    wr(ADDR_CORE_OPTIONS, 8'h07); pulse(2, 1'b0); repeat (3) @(posedge clk);
    `CHK("direct", 8, timeouts)
    $display("test watchdog done");
    wr(ADDR_CORE_OPTIONS, 8'h28); wr(ADDR_TIMER_COUNT, 8'h55);
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdReg(ADDR_TIMER_COUNT, rd); `CHK("kept", 8'h55, rd)
    rdReg(ADDR_CORE_OPTIONS, rd); `CHK("options2", 8'hFF, rd)
    rdReg(ADDR_INT_CONTROL, rd); `CHK("intctl2", 8'h00, rd)
    $display("test second reset done");
    completeRun();
  end
endmodule

`default_nettype wire

// ===== verification/tzwp_pin_source.sv
`timescale 1ns/10ps
`default_nettype none

module tzwp_pin_source #(
  parameter int HOLD_CYCLES = 4
) (
  // Clock.
  input  wire logic clk,
  // Count pin.
  output var  logic pin
);
  initial pin = 1'b0;

  // A level shorter than one cycle could slip past the synchroniser unseen.
  // Level hold time.
  task automatic toggle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      pin <= ~pin;
      repeat (HOLD_CYCLES - 1) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire
